// file: inc/pin_select_pkg.sv
// constants and types for the remappable output pin select block
// Function
// - each remappable pin has its own 6-bit output select field
// - all output select fields reset to zero, the null selection
// - no interlock between mapping registers; any combination is accepted
// - codes 000000 default port, 000001 uart transmit, 000010 uart request-to-send
// - codes 000101 spi data, 000110 spi clock, 000111 spi slave select
// - codes 010000 output compare, 011000 comparator a, 011001 comparator b
// - codes 101101 primary pwm sync, 101110 secondary pwm sync; others unassigned
// - analog-shared pins reset analog; port value and latch reads return zero
// - digital output driver still works while the analog function is enabled
// - highest-priority enabled function owns the pin; lower ones are inactive
// - each pin has pull-up and pull-down, each enabled by its own bit
// - at most one output function drives a pin at any time
// - an enabled dedicated output wins over any remappable output
// - any number of remappable inputs may sample one pin, even a driven one
// - direction control governs only gpio; active peripheral outputs enable the driver
// - the digital input buffer is gated only by the analog select bit
// - each peripheral input has an 8-bit select; n picks pin n, zero grounds
// - a remappable peripheral beats gpio but not an enabled dedicated output, and still drives analog ones
// - six virtual pins without pads behave like physical remappable pins
package pin_select_pkg;
   localparam int NPHYS = 8;
   localparam int NVIRT = 6;
   localparam int NRP = NPHYS + NVIRT;
   localparam int NPIN_IN = 8;
   localparam int SEL_W = 6;
   localparam int IN_SEL_W = 8;
   localparam logic [7:0] PHYS_FIRST_RP = 8'h01;
   localparam logic [7:0] VIRT_FIRST_RP = 8'hb0;
   // output select codes
   localparam logic [5:0] SEL_NULL = 6'h00;
   localparam logic [5:0] SEL_UART_TX = 6'h01;
   localparam logic [5:0] SEL_UART_RTS = 6'h02;
   localparam logic [5:0] SEL_SPI_DO = 6'h05;
   localparam logic [5:0] SEL_SPI_CLK = 6'h06;
   localparam logic [5:0] SEL_SPI_SS = 6'h07;
   localparam logic [5:0] SEL_OC = 6'h10;
   localparam logic [5:0] SEL_CMP_A = 6'h18;
   localparam logic [5:0] SEL_CMP_B = 6'h19;
   localparam logic [5:0] SEL_SYNC_P = 6'h2d;
   localparam logic [5:0] SEL_SYNC_S = 6'h2e;
   // register byte offsets
   localparam logic [11:0] OFS_OUT_MAP = 12'h000;
   localparam logic [11:0] OFS_IN_MAP = 12'h040;
   localparam logic [11:0] OFS_ANSEL = 12'h080;
   localparam logic [11:0] OFS_DIR = 12'h084;
   localparam logic [11:0] OFS_LATCH = 12'h088;
   localparam logic [11:0] OFS_PORT = 12'h08c;
   localparam logic [11:0] OFS_PULLUP = 12'h090;
   localparam logic [11:0] OFS_PULLDN = 12'h094;
   localparam logic [11:0] OFS_PIN_IN = 12'h098;
   // reset values
   localparam logic [7:0] ANALOG_SHARED = 8'h3f;
   localparam logic [7:0] ANSEL_RST = 8'h3f;
   localparam logic [7:0] DIR_RST = 8'hff;

   typedef struct packed {
      logic uart_transmit_out;
      logic uart_request_to_send_out;
      logic spi_data_out;
      logic spi_clock_out;
      logic spi_slave_select_out;
      logic output_compare_out;
      logic comparator_a_out;
      logic comparator_b_out;
      logic pwm_primary_sync_out;
      logic pwm_secondary_sync_out;
   } periph_out_t;

   function automatic logic [7:0] rp_num(input int i);
      if (i < NPHYS)
         rp_num = PHYS_FIRST_RP + 8'(i);
      else
         rp_num = VIRT_FIRST_RP + 8'(i - NPHYS);
   endfunction : rp_num
endpackage : pin_select_pkg

// file: verilog/out_select_mux.sv
// one remappable pin's output source multiplexer
`timescale 1ns/1ps
module out_select_mux
   import pin_select_pkg::*;
(
   // selection
   input wire logic [SEL_W-1:0] sel,
   input wire periph_out_t src,
   // result
   output logic value,
   output logic active
);
   always_comb
   begin
      value = 1'b0;
      active = 1'b1;
      unique case (sel)
         SEL_UART_TX: value = src.uart_transmit_out;
         SEL_UART_RTS: value = src.uart_request_to_send_out;
         SEL_SPI_DO: value = src.spi_data_out;
         SEL_SPI_CLK: value = src.spi_clock_out;
         SEL_SPI_SS: value = src.spi_slave_select_out;
         SEL_OC: value = src.output_compare_out;
         SEL_CMP_A: value = src.comparator_a_out;
         SEL_CMP_B: value = src.comparator_b_out;
         SEL_SYNC_P: value = src.pwm_primary_sync_out;
         SEL_SYNC_S: value = src.pwm_secondary_sync_out;
         // null and unassigned codes leave the pin to its port function
         default: active = 1'b0;
      endcase
   end
endmodule : out_select_mux

// file: verilog/pin_select_top.sv
// remappable pin select: apb registers, output muxing, pin priority, input mapping
`timescale 1ns/1ps
module pin_select_top
   import pin_select_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // peripheral side
   input wire periph_out_t PERIPH_OUT,
   input wire logic [NPHYS-1:0] DED_OE,
   input wire logic [NPHYS-1:0] DED_OUT,
   output logic [NPIN_IN-1:0] PERIPH_IN,
   // pad side
   input wire logic [NPHYS-1:0] PAD_IN,
   output logic [NPHYS-1:0] PAD_OUT,
   output logic [NPHYS-1:0] PAD_OE,
   output logic [NPHYS-1:0] PAD_PULLUP,
   output logic [NPHYS-1:0] PAD_PULLDN,
   output logic [NPHYS-1:0] ANALOG_EN
);
   logic [SEL_W-1:0] out_sel_reg [NRP];
   logic [IN_SEL_W-1:0] in_sel_reg [NPIN_IN];
   logic [NPHYS-1:0] ansel_reg;
   logic [NPHYS-1:0] dir_reg;
   logic [NPHYS-1:0] latch_reg;
   logic [NPHYS-1:0] pullup_reg;
   logic [NPHYS-1:0] pulldn_reg;
   logic [NPHYS-1:0] sync1_reg;
   logic [NPHYS-1:0] sync2_reg;
   logic [NPHYS-1:0] sync3_reg;
   logic [NPHYS-1:0] filt_reg;
   logic [NPHYS-1:0] pad_out_reg;
   logic [NPHYS-1:0] pad_oe_reg;
   logic [NVIRT-1:0] virt_out_reg;
   logic [NPIN_IN-1:0] periph_in_reg;
   logic [NPIN_IN-1:0] periph_in_next;
   logic [NPHYS-1:0] pad_out_next;
   logic [NPHYS-1:0] pad_oe_next;
   logic [NVIRT-1:0] virt_out_next;
   logic [NRP-1:0] remap_val;
   logic [NRP-1:0] remap_act;
   logic [NRP-1:0] pin_in;
   logic [NPHYS-1:0] port_read;
   logic [NPHYS-1:0] latch_read;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic setup_phase;
   logic wr_access;
   logic out_map_hit;
   logic in_map_hit;
   logic [3:0] out_idx;
   logic [2:0] in_idx;

   // apb decode
   assign setup_phase = PSEL & ~PENABLE;
   assign wr_access = PSEL & PENABLE & PWRITE;
   assign out_idx = PADDR[5:2];
   assign in_idx = PADDR[4:2];
   assign out_map_hit = (PADDR[11:6] == OFS_OUT_MAP[11:6]) && (int'(out_idx) < NRP);
   assign in_map_hit = (PADDR[11:5] == OFS_IN_MAP[11:5]);

   // output mapping registers; any value is stored, nothing is cross-checked
   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         for (int i = 0; i < NRP; i++)
            out_sel_reg[i] <= SEL_NULL;
      end
      else if (wr_access && out_map_hit)
         out_sel_reg[out_idx] <= PWDATA[SEL_W-1:0];
   end

   // input mapping registers
   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         for (int j = 0; j < NPIN_IN; j++)
            in_sel_reg[j] <= 8'h00;
      end
      else if (wr_access && in_map_hit)
         in_sel_reg[in_idx] <= PWDATA[IN_SEL_W-1:0];
   end

   // port configuration registers
   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         ansel_reg <= ANSEL_RST;
         dir_reg <= DIR_RST;
         latch_reg <= '0;
         pullup_reg <= '0;
         pulldn_reg <= '0;
      end
      else if (wr_access)
      begin
         unique case (PADDR)
            // only analog-shared pins own an analog select bit
            OFS_ANSEL: ansel_reg <= PWDATA[NPHYS-1:0] & ANALOG_SHARED;
            OFS_DIR: dir_reg <= PWDATA[NPHYS-1:0];
            OFS_LATCH: latch_reg <= PWDATA[NPHYS-1:0];
            OFS_PULLUP: pullup_reg <= PWDATA[NPHYS-1:0];
            OFS_PULLDN: pulldn_reg <= PWDATA[NPHYS-1:0];
            default: ;
         endcase
      end
   end

   // pad input synchroniser; a change is taken once stages two and three agree
   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         filt_reg <= '0;
      end
      else
      begin
         sync1_reg <= PAD_IN;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         for (int i = 0; i < NPHYS; i++)
            if (sync2_reg[i] == sync3_reg[i])
               filt_reg[i] <= sync3_reg[i];
      end
   end

   // per-pin source selection
   genvar g;
   generate
      for (g = 0; g < NRP; g++)
      begin : g_mux
         out_select_mux u_mux (
            .sel(out_sel_reg[g]),
            .src(PERIPH_OUT),
            .value(remap_val[g]),
            .active(remap_act[g])
         );
      end
   endgenerate

   // one owner per pin: dedicated, then remappable, then gpio
   always_comb
   begin
      for (int i = 0; i < NPHYS; i++)
      begin
         if (DED_OE[i])
         begin
            pad_out_next[i] = DED_OUT[i];
            pad_oe_next[i] = 1'b1;
         end
         else if (remap_act[i])
         begin
            pad_out_next[i] = remap_val[i];
            pad_oe_next[i] = 1'b1;
         end
         else
         begin
            // analog select does not gate the gpio driver
            pad_out_next[i] = latch_reg[i] & ~dir_reg[i];
            pad_oe_next[i] = ~dir_reg[i];
         end
      end
      for (int k = 0; k < NVIRT; k++)
         virt_out_next[k] = remap_act[NPHYS+k] & remap_val[NPHYS+k];
   end

   // registered drive so that a selection change lands glitch free one cycle later
   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         pad_out_reg <= '0;
         pad_oe_reg <= '0;
         virt_out_reg <= '0;
      end
      else
      begin
         pad_out_reg <= pad_out_next;
         pad_oe_reg <= pad_oe_next;
         virt_out_reg <= virt_out_next;
      end
   end

   // input view of every remappable pin; the buffer follows analog select only
   always_comb
   begin
      for (int i = 0; i < NPHYS; i++)
         pin_in[i] = filt_reg[i] & ~ansel_reg[i];
      for (int k = 0; k < NVIRT; k++)
         pin_in[NPHYS+k] = virt_out_reg[k];
      port_read = filt_reg & ~ansel_reg;
      latch_read = latch_reg & ~ansel_reg;
   end

   // each peripheral input picks one pin; many inputs may share a pin
   always_comb
   begin
      for (int j = 0; j < NPIN_IN; j++)
      begin
         periph_in_next[j] = 1'b0;
         for (int i = 0; i < NRP; i++)
            if (in_sel_reg[j] == rp_num(i))
               periph_in_next[j] = pin_in[i];
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         periph_in_reg <= '0;
      else
         periph_in_reg <= periph_in_next;
   end

   // read data is prepared during setup and presented in the access phase
   always_comb
   begin
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (out_map_hit)
         prdata_next[SEL_W-1:0] = out_sel_reg[out_idx];
      else if (in_map_hit)
         prdata_next[IN_SEL_W-1:0] = in_sel_reg[in_idx];
      else
      begin
         unique case (PADDR)
            OFS_ANSEL: prdata_next[NPHYS-1:0] = ansel_reg;
            OFS_DIR: prdata_next[NPHYS-1:0] = dir_reg;
            OFS_LATCH: prdata_next[NPHYS-1:0] = latch_read;
            OFS_PORT: prdata_next[NPHYS-1:0] = port_read;
            OFS_PULLUP: prdata_next[NPHYS-1:0] = pullup_reg;
            OFS_PULLDN: prdata_next[NPHYS-1:0] = pulldn_reg;
            OFS_PIN_IN: prdata_next[NPIN_IN-1:0] = periph_in_reg;
            default: pslverr_next = 1'b1;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata_reg <= PWRITE ? 32'h0000_0000 : prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = 1'b1;
   assign PSLVERR = pslverr_reg & PSEL & PENABLE;
   assign PAD_OUT = pad_out_reg;
   assign PAD_OE = pad_oe_reg;
   assign PAD_PULLUP = pullup_reg;
   assign PAD_PULLDN = pulldn_reg;
   assign ANALOG_EN = ansel_reg;
   assign PERIPH_IN = periph_in_reg;

   // checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   logic rst_seen_reg;
   always_ff @(posedge SYS_CLK)
      rst_seen_reg <= !RSTN;

   a_reset_null_map: assert property (
      rst_seen_reg |-> (out_sel_reg[0] == SEL_NULL && out_sel_reg[NRP-1] == SEL_NULL && !PAD_OE[0]))
      else $error("output select not null after reset");

   a_reset_analog_mode: assert property (
      rst_seen_reg |-> (ansel_reg == ANSEL_RST && port_read[0] == 1'b0))
      else $error("analog-shared pin not analog after reset");

   a_analog_reads_zero: assert property (
      ansel_reg[0] |-> (!port_read[0] && !latch_read[0]))
      else $error("analog pin read returned one");

   a_dedicated_wins: assert property (
      DED_OE[1] |=> (PAD_OE[1] && PAD_OUT[1] == $past(DED_OUT[1])))
      else $error("dedicated output lost the pin");

   a_remap_overrides_dir: assert property (
      (!DED_OE[2] && remap_act[2] && dir_reg[2]) |=> (PAD_OE[2] && PAD_OUT[2] == $past(remap_val[2])))
      else $error("remapped output not driving input-direction pin");

   a_uart_code_route: assert property (
      (out_sel_reg[0] == SEL_UART_TX && !DED_OE[0]) |=> PAD_OUT[0] == $past(PERIPH_OUT.uart_transmit_out))
      else $error("uart transmit not routed");

   a_sync_code_route: assert property (
      (out_sel_reg[3] == SEL_SYNC_S && !DED_OE[3]) ##1 PAD_OE[3] |-> PAD_OUT[3] == $past(PERIPH_OUT.pwm_secondary_sync_out))
      else $error("secondary sync not routed");

   a_gpio_input_idle: assert property (
      (!DED_OE[4] && out_sel_reg[4] == SEL_NULL && dir_reg[4]) |=> !PAD_OE[4])
      else $error("input pin driven with no owner");

   a_input_grounded: assert property (
      (in_sel_reg[0] == 8'h00) [*2] |-> !PERIPH_IN[0])
      else $error("unselected peripheral input not grounded");

   a_input_analog_gate: assert property (
      (in_sel_reg[0] == PHYS_FIRST_RP && ansel_reg[0]) [*2] |-> !PERIPH_IN[0])
      else $error("analog pin reached a digital input");

   a_virtual_loop: assert property (
      (in_sel_reg[7] == VIRT_FIRST_RP && out_sel_reg[NPHYS] == SEL_UART_TX) [*3]
         |-> PERIPH_IN[7] == $past(PERIPH_OUT.uart_transmit_out, 2))
      else $error("virtual pin loop broken");

   c_dedicated_drive: cover property (DED_OE[0] ##1 PAD_OE[0]);
   c_remap_drive: cover property (!DED_OE[0] && remap_act[0] ##1 PAD_OE[0]);
   c_virtual_use: cover property (in_sel_reg[7] == VIRT_FIRST_RP && virt_out_reg[0]);
   c_shared_input: cover property (in_sel_reg[1] == in_sel_reg[2] && in_sel_reg[1] != 8'h00);
endmodule : pin_select_top

// file: tb/pin_select_partner.sv
// far-side model: peripheral outputs, dedicated pin functions and pad levels
`timescale 1ns/1ps
module pin_select_partner
   import pin_select_pkg::*;
(
   // clock and control from the bench
   input wire logic clk,
   input wire logic wiggle,
   input wire logic [31:0] rnd,
   input wire logic [7:0] ext_val,
   // pad side of the block
   input wire logic [NPHYS-1:0] pad_out,
   input wire logic [NPHYS-1:0] pad_oe,
   input wire logic [NPHYS-1:0] pad_pu,
   input wire logic [NPHYS-1:0] pad_pd,
   output logic [NPHYS-1:0] pad_in,
   // peripheral side of the block
   output periph_out_t periph,
   output logic [NPHYS-1:0] ded_oe,
   output logic [NPHYS-1:0] ded_out
);
   initial
   begin
      periph = periph_out_t'(10'h000);
      ded_oe = 8'h00;
      ded_out = 8'h00;
   end
   // outputs move only after an edge, like any logic in this domain
   always @(posedge clk)
   begin
      if (wiggle)
      begin
         periph <= periph_out_t'(rnd[9:0]);
         ded_oe <= rnd[17:10] & rnd[25:18];
         ded_out <= rnd[31:24];
      end
      else
         ded_oe <= 8'h00;
   end
   // a driven pad reads back its own level; else the pulls, else the outside source
   always_comb
      for (int i = 0; i < NPHYS; i++)
         pad_in[i] = pad_oe[i] ? pad_out[i] : (pad_pu[i] ? 1'b1 : (pad_pd[i] ? 1'b0 : ext_val[i]));
endmodule : pin_select_partner

// file: tb/remappable_output_pin_select_test.sv
// self-checking bench for the remappable output pin select block
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module remappable_output_pin_select_test
   import pin_select_pkg::*;
   ;
   localparam logic [5:0] CODES [13] = '{SEL_NULL, SEL_UART_TX, SEL_UART_RTS, SEL_SPI_DO, SEL_SPI_CLK,
      SEL_SPI_SS, SEL_OC, SEL_CMP_A, SEL_CMP_B, SEL_SYNC_P, SEL_SYNC_S, 6'h03, 6'h3f};
   logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wiggle = 1'b0;
   logic chk_en = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rnd = 32'h0, prdata, rd;
   periph_out_t periph;
   logic [NPHYS-1:0] ded_oe, ded_out, pad_in, pad_out, pad_oe, pad_pu, pad_pd, analog_en;
   logic [NPIN_IN-1:0] periph_in, exp_in;
   logic [7:0] ext_val = 8'ha5, dir_m = 8'hff, latch_m = 8'h00, ansel_m = 8'h3f, lvl;
   logic [5:0] sel_m [NPHYS] = '{default: 6'h00};
   logic [2*NPHYS-1:0] exp_q = 16'h0000;
   int n_mismatch = 0, comparisons = 0, cycles = 0, k, i;

   always #4 sys_clk = ~sys_clk;

   pin_select_top dut_u (.SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PERIPH_OUT(periph), .DED_OE(ded_oe), .DED_OUT(ded_out), .PERIPH_IN(periph_in), .PAD_IN(pad_in),
      .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULLUP(pad_pu), .PAD_PULLDN(pad_pd), .ANALOG_EN(analog_en));

   pin_select_partner far_u (.clk(sys_clk), .wiggle(wiggle), .rnd(rnd), .ext_val(ext_val),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_in(pad_in),
      .periph(periph), .ded_oe(ded_oe), .ded_out(ded_out));

   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   // {valid, level} of one select code; unassigned codes act as null
   function automatic logic [1:0] route(input logic [5:0] s, input periph_out_t p);
      case (s)
         SEL_UART_TX: route = {1'b1, p.uart_transmit_out};
         SEL_UART_RTS: route = {1'b1, p.uart_request_to_send_out};
         SEL_SPI_DO: route = {1'b1, p.spi_data_out};
         SEL_SPI_CLK: route = {1'b1, p.spi_clock_out};
         SEL_SPI_SS: route = {1'b1, p.spi_slave_select_out};
         SEL_OC: route = {1'b1, p.output_compare_out};
         SEL_CMP_A: route = {1'b1, p.comparator_a_out};
         SEL_CMP_B: route = {1'b1, p.comparator_b_out};
         SEL_SYNC_P: route = {1'b1, p.pwm_primary_sync_out};
         SEL_SYNC_S: route = {1'b1, p.pwm_secondary_sync_out};
         default: route = 2'b00;
      endcase
   endfunction : route

   // expected {oe, out} of the physical pads; analog select never gates the driver
   function automatic logic [2*NPHYS-1:0] drive(input periph_out_t p, input logic [NPHYS-1:0] doe, dout);
      logic [1:0] r;
      drive = 16'h0000;
      for (int n = 0; n < NPHYS; n++)
      begin
         r = route(sel_m[n], p);
         if (doe[n])
            {drive[NPHYS+n], drive[n]} = {1'b1, dout[n]};
         else if (r[1])
            {drive[NPHYS+n], drive[n]} = {1'b1, r[0]};
         else if (!dir_m[n])
            {drive[NPHYS+n], drive[n]} = {1'b1, latch_m[n]};
      end
   endfunction : drive

   always @(posedge sys_clk)
      rnd <= $urandom();

   // pads follow one cycle after their causes
   always @(posedge sys_clk)
   begin
      cycles++;
      if (chk_en)
         `CHK({pad_oe, pad_out}, exp_q)
      exp_q <= rstn ? drive(periph, ded_oe, ded_out) : 16'h0000;
      if (cycles == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   // one APB transfer; the mirror moves at the completing edge, as the registers do
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // the wait ends at the first edge that sees pready high
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      if (w && a < 12'h020)
         sel_m[a[4:2]] <= d[5:0];
      if (w && a == OFS_DIR)
         dir_m <= d[7:0];
      if (w && a == OFS_LATCH)
         latch_m <= d[7:0];
      if (w && a == OFS_ANSEL)
         ansel_m <= d[7:0] & ANALOG_SHARED;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rchk

   initial
   begin
      void'($urandom(32'h8fa0179a));
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      chk_en <= 1'b1;
      for (i = 0; i < NRP; i++)
         rchk(OFS_OUT_MAP + 12'(4*i), 32'h0);
      for (i = 0; i < NPIN_IN; i++)
         rchk(OFS_IN_MAP + 12'(4*i), 32'h0);
      rchk(OFS_ANSEL, 32'h3f);
      rchk(OFS_DIR, 32'hff);
      rchk(OFS_LATCH, 32'h0);
      rchk(OFS_PULLUP, 32'h0);
      rchk(OFS_PORT, {24'h0, ext_val & ~ANALOG_SHARED});
      `CHK(analog_en, ANSEL_RST)
      apb(1'b0, 12'h0fc, 32'h0);
      `CHK({err, rd}, 33'h100000000)
      // every assigned code, null and two unassigned codes on every physical pin, many pins sharing one source
      wiggle <= 1'b1;
      for (k = 0; k < 13; k++)
         for (i = 0; i < NPHYS; i++)
         begin
            apb(1'b1, OFS_OUT_MAP + 12'(4*i), {26'h3ffffff, CODES[k]});
            rchk(OFS_OUT_MAP + 12'(4*i), {26'h0, CODES[k]});
         end
      repeat (200)
      begin
         k = $urandom_range(12);
         i = $urandom_range(7);
         case ($urandom_range(3))
            0: apb(1'b1, OFS_OUT_MAP + 12'(4*i), {26'h0, CODES[k]});
            1: apb(1'b1, OFS_DIR, $urandom());
            2: apb(1'b1, OFS_LATCH, $urandom());
            default: apb(1'b1, OFS_ANSEL, $urandom());
         endcase
         `CHK(analog_en, ansel_m)
      end
      // inputs: digital pins, one driven pin sampled twice, one virtual pin, one grounded input
      wiggle <= 1'b0;
      apb(1'b1, OFS_ANSEL, 32'h0);
      apb(1'b1, OFS_DIR, 32'hff);
      for (i = 0; i < NRP; i++)
         apb(1'b1, OFS_OUT_MAP + 12'(4*i), {26'h0, i == 1 ? SEL_CMP_A : (i == 8 ? SEL_UART_TX : SEL_NULL)});
      apb(1'b1, OFS_PULLUP, 32'h0f);
      apb(1'b1, OFS_PULLDN, 32'h30);
      for (i = 0; i < NPIN_IN; i++)
         apb(1'b1, OFS_IN_MAP + 12'(4*i), i == 6 ? 32'h0 : (i == 7 ? 32'hb0 : (i == 2 ? 32'h2 : 32'(i + 1))));
      repeat (6) @(posedge sys_clk);
      lvl = 8'h0f | (ext_val & 8'hc0);
      lvl[1] = periph.comparator_a_out;
      exp_in = {periph.uart_transmit_out, 1'b0, lvl[5], lvl[4], lvl[3], lvl[1], lvl[1], lvl[0]};
      rchk(OFS_PORT, {24'h0, lvl});
      `CHK({pad_pu, pad_pd}, 16'h0f30)
      `CHK(periph_in, exp_in)
      rchk(OFS_PIN_IN, {24'h0, exp_in});
      rchk(OFS_PULLDN, 32'h30);
      apb(1'b1, OFS_ANSEL, 32'hff);
      repeat (6) @(posedge sys_clk);
      rchk(OFS_PORT, {24'h0, lvl & ~ANALOG_SHARED});
      rchk(OFS_LATCH, {24'h0, latch_m & ~ANALOG_SHARED});
      give_verdict();
   end
endmodule : remappable_output_pin_select_test
